// ### hdl/uhrc_top.sv
/*
  command and status control of an enhanced host: run/stop with halting handshake,
  controller soft reset, fixed frame list size, host system error and interrupts.
  assumes a single 25 MHz clock, a plain one-cycle register strobe port and a
  schedule engine that reports when its current bus transaction ends.
*/
// Implementation choices: the register offsets and the plain strobed port.
// Functional notes
// [RULE_01] frame list size field reads zero, writes ignored
// [RULE_02] soft reset write of one resets all internal state; the interrupt enable and event status registers here keep their values
// [RULE_03] soft reset acts on root hub registers like a chip reset
// [RULE_04] no bus reset signalled on downstream ports during soft reset
// [RULE_05] config and capability registers untouched by soft reset
// [RULE_06] soft reset restores port registers, ports go to companion
// [RULE_07] hardware clears soft reset bit when done; writing zero cannot end it
// [RULE_08] software reinitialises the controller after a soft reset
// [RULE_09] software avoids soft reset while halted flag is zero
// [RULE_10] schedule executes while run bit is one
// [RULE_11] run cleared: finish transaction, then halt and set halted flag
// [RULE_12] software sets run only while halted flag is one
// [RULE_13] halted flag clears at once when run is set
// [RULE_14] run/halted pairs mean halting, halted, running
// [RULE_15] every command register write is a command
// [RULE_16] halted flag sets once stopped after run clears; resets to one
// [RULE_17] failed memory read sets host system error and interrupts
// [RULE_18] soft reset bit reads one while reset runs
`include "uhrc_consts.svh"
module uhrc_top #(
  parameter int PORTS = 8,
  parameter int SRST_CYCLES = `UHRC_SRST_CYCLES,
  parameter logic [31:0] CAP_ID = 32'h0000A5A5 // arbitrary value
) (
  // clock and reset
  input wire logic clk_sys_in,
  input wire logic nrst_in,
  // register port
  input wire logic [7:0] reg_addr_in,
  input wire uhrc_pkg::uhrc_word_t reg_wdata_in,
  input wire logic reg_wr_in,
  input wire logic reg_rd_in,
  output uhrc_pkg::uhrc_word_t reg_rdata_out,
  // schedule engine
  input wire logic xact_busy_in,
  input wire logic mem_rd_done_in,
  input wire logic mem_rd_ok_in,
  input wire logic int_error_in,
  output logic sched_run_out,
  output logic engine_reset_out,
  // downstream ports
  output logic [PORTS-1:0] port_owner_out,
  output logic [PORTS-1:0] port_enable_out,
  output logic [PORTS-1:0] port_bus_reset_out,
  // interrupt
  output logic irq_out
);
  import uhrc_pkg::*;

  // ----------------------------------------
  // declarations
  // ----------------------------------------
  uhrc_state_t state_ff;
  uhrc_state_t nxt_state;
  logic run_ff;
  logic halted_ff;
  logic hse_ff;
  logic [`UHRC_EV_COUNT-1:0] ev_sts_ff;
  logic [`UHRC_EV_COUNT-1:0] ev_en_ff;
  logic [`UHRC_EV_COUNT-1:0] ev_set;
  logic [`UHRC_EV_COUNT-1:0] ev_clr;
  uhrc_word_t rdata_ff;
  uhrc_word_t nxt_rdata;
  logic sched_run_ff;
  logic eng_rst_ff;
  logic irq_ff;
  logic [PORTS-1:0] port_owner_ff;
  logic [PORTS-1:0] port_enable_ff;
  logic [PORTS-1:0] owner_w;
  logic [PORTS-1:0] enable_w;
  logic cmd_wr;
  logic srst_start;
  logic srst_busy;
  logic srst_done;
  logic srst_act;
  logic port_wr;
  logic hse_event;
  logic halt_event;

  // ----------------------------------------
  // write decode
  // ----------------------------------------
  // any write to the command word is a command, even one repeating current bits
  assign cmd_wr = reg_wr_in && reg_addr_in == `UHRC_OFF_CMD; // [RULE_15]
  assign srst_start = cmd_wr && reg_wdata_in[`UHRC_CMD_SRST_BIT] && !srst_busy; // [RULE_02]
  assign srst_act = srst_start || srst_busy;
  assign port_wr = reg_wr_in && reg_addr_in >= `UHRC_OFF_PORT &&
                   reg_addr_in < 8'(`UHRC_OFF_PORT + 4 * PORTS);

  // ----------------------------------------
  // soft reset sequencer
  // ----------------------------------------
  uhrc_srst_timer #(
    .CYCLES(SRST_CYCLES)
  ) u_srst (
    .clk_sys_in(clk_sys_in),
    .nrst_in(nrst_in),
    .start_in(srst_start),
    .busy_out(srst_busy),
    .done_out(srst_done)
  );

  // ----------------------------------------
  // root hub port state
  // ----------------------------------------
  uhrc_port_ctl #(
    .PORTS(PORTS)
  ) u_ports (
    .clk_sys_in(clk_sys_in),
    .nrst_in(nrst_in),
    .srst_in(srst_act),
    .wr_in(port_wr),
    .wr_sel_in(8'((reg_addr_in - `UHRC_OFF_PORT) >> 2)),
    .wr_data_in(reg_wdata_in[1:0]),
    .owner_out(owner_w),
    .enable_out(enable_w)
  );

  // ----------------------------------------
  // run state machine
  // ----------------------------------------
  always_comb begin
    nxt_state = state_ff;
    case (state_ff)
      UHRC_ST_HALTED: begin
        if (run_ff) begin
          nxt_state = UHRC_ST_RUNNING; // [RULE_13]
        end
      end
      UHRC_ST_RUNNING: begin
        if (!run_ff) begin
          nxt_state = UHRC_ST_HALTING; // [RULE_10]
        end
      end
      UHRC_ST_HALTING: begin
        if (!xact_busy_in) begin
          nxt_state = UHRC_ST_HALTED; // [RULE_11]
        end
      end
      UHRC_ST_SRST: begin
        if (!srst_busy) begin
          nxt_state = UHRC_ST_HALTED;
        end
      end
      default: begin
        nxt_state = UHRC_ST_HALTED;
      end
    endcase
    if (srst_start) begin
      nxt_state = UHRC_ST_SRST; // [RULE_02]
    end
  end

  // state register; soft reset forces the machine back [RULE_02]
  always_ff @(posedge clk_sys_in) begin
    if (!nrst_in) begin
      state_ff <= UHRC_ST_HALTED;
    end else begin
      state_ff <= nxt_state;
    end
  end

  // ----------------------------------------
  // run/stop bit
  // ----------------------------------------
  // internal error drops run just as software would
  always_ff @(posedge clk_sys_in) begin
    if (!nrst_in) begin
      run_ff <= 1'b0;
    end else if (srst_act) begin
      run_ff <= 1'b0;
    end else if (int_error_in) begin
      run_ff <= 1'b0;
    end else if (cmd_wr) begin
      run_ff <= reg_wdata_in[`UHRC_CMD_RUN_BIT];
    end
  end

  // ----------------------------------------
  // halted flag
  // ----------------------------------------
  // cleared in the same edge that sets run, so run and halted both read one only if run is set again while halting
  always_ff @(posedge clk_sys_in) begin
    if (!nrst_in) begin
      halted_ff <= 1'b1; // [RULE_16]
    end else if (cmd_wr && reg_wdata_in[`UHRC_CMD_RUN_BIT] && !srst_act && !int_error_in) begin
      halted_ff <= 1'b0; // [RULE_13]
    end else if (nxt_state == UHRC_ST_HALTED || nxt_state == UHRC_ST_SRST) begin
      halted_ff <= 1'b1; // [RULE_16]
    end
  end

  // ----------------------------------------
  // schedule drive
  // ----------------------------------------
  // halting keeps the engine on so the transaction in flight can end
  always_ff @(posedge clk_sys_in) begin
    if (!nrst_in) begin
      sched_run_ff <= 1'b0;
    end else begin
      sched_run_ff <= (nxt_state == UHRC_ST_RUNNING) || (nxt_state == UHRC_ST_HALTING); // [RULE_14]
    end
  end

  // engine pipelines, timers and counters held in reset during soft reset
  always_ff @(posedge clk_sys_in) begin
    if (!nrst_in) begin
      eng_rst_ff <= 1'b1;
    end else begin
      eng_rst_ff <= srst_act; // [RULE_02]
    end
  end

  // ----------------------------------------
  // port outputs
  // ----------------------------------------
  // bus reset stays low through soft reset; only port state is restored
  always_ff @(posedge clk_sys_in) begin
    if (!nrst_in) begin
      port_owner_ff <= '1;
      port_enable_ff <= '0;
      port_bus_reset_out <= '0;
    end else begin
      port_owner_ff <= srst_act ? '1 : owner_w; // [RULE_06]
      port_enable_ff <= srst_act ? '0 : enable_w;
      port_bus_reset_out <= '0; // [RULE_04]
    end
  end

  // ----------------------------------------
  // host system error flag
  // ----------------------------------------
  assign hse_event = mem_rd_done_in && !mem_rd_ok_in;
  assign halt_event = (nxt_state == UHRC_ST_HALTED) && (state_ff == UHRC_ST_HALTING);

  // write one to clear, a new error in the same cycle wins
  always_ff @(posedge clk_sys_in) begin
    if (!nrst_in) begin
      hse_ff <= 1'b0;
    end else if (hse_event) begin
      hse_ff <= 1'b1; // [RULE_17]
    end else if (srst_act) begin
      hse_ff <= 1'b0;
    end else if (reg_wr_in && reg_addr_in == `UHRC_OFF_STS && reg_wdata_in[`UHRC_STS_HSE_BIT]) begin
      hse_ff <= 1'b0;
    end
  end

  // ----------------------------------------
  // interrupt status, enable, clear
  // ----------------------------------------
  always_comb begin
    ev_set = '0;
    ev_set[`UHRC_EV_HSE] = hse_event; // [RULE_17]
    ev_set[`UHRC_EV_HALTED] = halt_event;
    ev_set[`UHRC_EV_SRST_DONE] = srst_done;
    ev_clr = '0;
    if (reg_wr_in && reg_addr_in == `UHRC_OFF_INT_CLR) begin
      ev_clr = reg_wdata_in[`UHRC_EV_COUNT-1:0];
    end
  end

  // set beats clear in the same cycle
  always_ff @(posedge clk_sys_in) begin
    if (!nrst_in) begin
      ev_sts_ff <= '0;
    end else begin
      ev_sts_ff <= ev_set | (ev_sts_ff & ~ev_clr);
    end
  end

  // enable register survives soft reset like other software config
  always_ff @(posedge clk_sys_in) begin
    if (!nrst_in) begin
      ev_en_ff <= '0;
    end else if (reg_wr_in && reg_addr_in == `UHRC_OFF_INT_EN) begin
      ev_en_ff <= reg_wdata_in[`UHRC_EV_COUNT-1:0];
    end
  end

  always_ff @(posedge clk_sys_in) begin
    if (!nrst_in) begin
      irq_ff <= 1'b0;
    end else begin
      irq_ff <= |((ev_set | (ev_sts_ff & ~ev_clr)) & ev_en_ff);
    end
  end

  // ----------------------------------------
  // read mux
  // ----------------------------------------
  // capability word is a constant, so soft reset cannot disturb it
  always_comb begin
    nxt_rdata = '0;
    case (reg_addr_in)
      `UHRC_OFF_CMD: begin
        nxt_rdata[`UHRC_CMD_RUN_BIT] = run_ff;
        nxt_rdata[`UHRC_CMD_SRST_BIT] = srst_busy; // [RULE_18]
        nxt_rdata[`UHRC_CMD_FLS_HI:`UHRC_CMD_FLS_LO] = `UHRC_FLS_VALUE; // [RULE_01]
      end
      `UHRC_OFF_STS: begin
        nxt_rdata[`UHRC_STS_HALT_BIT] = halted_ff; // [RULE_14]
        nxt_rdata[`UHRC_STS_HSE_BIT] = hse_ff;
      end
      `UHRC_OFF_INT_EN: begin
        nxt_rdata[`UHRC_EV_COUNT-1:0] = ev_en_ff;
      end
      `UHRC_OFF_INT_CLR: begin
        nxt_rdata[`UHRC_EV_COUNT-1:0] = ev_sts_ff;
      end
      8'hFC: begin
        nxt_rdata = CAP_ID; // [RULE_05]
      end
      default: begin
        if (reg_addr_in >= `UHRC_OFF_PORT && reg_addr_in < 8'(`UHRC_OFF_PORT + 4 * PORTS)) begin
          nxt_rdata[`UHRC_PORT_OWNER_BIT] = owner_w[3'((reg_addr_in - `UHRC_OFF_PORT) >> 2)];
          nxt_rdata[`UHRC_PORT_ENABLE_BIT] = enable_w[3'((reg_addr_in - `UHRC_OFF_PORT) >> 2)];
        end
      end
    endcase
  end

  // read data valid only in the cycle after the strobe
  always_ff @(posedge clk_sys_in) begin
    if (!nrst_in) begin
      rdata_ff <= '0;
    end else if (reg_rd_in) begin
      rdata_ff <= nxt_rdata;
    end else begin
      rdata_ff <= '0;
    end
  end

  // ----------------------------------------
  // outputs
  // ----------------------------------------
  assign reg_rdata_out = rdata_ff;
  assign sched_run_out = sched_run_ff;
  assign engine_reset_out = eng_rst_ff;
  assign port_owner_out = port_owner_ff;
  assign port_enable_out = port_enable_ff;
  assign irq_out = irq_ff;
endmodule

// ### hdl/uhrc_consts.svh
/*
  constants of the run/stop and soft reset block.
  assumes inclusion by bare name from the package and the design modules.
*/
`ifndef UHRC_CONSTS_SVH
`define UHRC_CONSTS_SVH

// ----------------------------------------
// register byte offsets
// ----------------------------------------
`define UHRC_OFF_CMD 8'h00
`define UHRC_OFF_STS 8'h04
`define UHRC_OFF_INT_EN 8'h08
`define UHRC_OFF_INT_CLR 8'h0C
`define UHRC_OFF_PORT 8'h10

// ----------------------------------------
// command register fields
// ----------------------------------------
`define UHRC_CMD_RUN_BIT 0
`define UHRC_CMD_SRST_BIT 1
`define UHRC_CMD_FLS_LO 2
`define UHRC_CMD_FLS_HI 3
`define UHRC_FLS_VALUE 2'h0

// ----------------------------------------
// status register fields
// ----------------------------------------
`define UHRC_STS_HSE_BIT 4
`define UHRC_STS_HALT_BIT 12
`define UHRC_STS_RESET 32'h00001000

// ----------------------------------------
// interrupt event bits (status, enable and clear share them)
// ----------------------------------------
`define UHRC_EV_HSE 0
`define UHRC_EV_HALTED 1
`define UHRC_EV_SRST_DONE 2
`define UHRC_EV_COUNT 3

// ----------------------------------------
// port register fields
// ----------------------------------------
`define UHRC_PORT_OWNER_BIT 0
`define UHRC_PORT_ENABLE_BIT 1

// ----------------------------------------
// timing
// ----------------------------------------
`define UHRC_SRST_CYCLES 25 // 1000 ns at 40 ns a cycle

`endif

// ### hdl/uhrc_pkg.sv
/*
  types shared by the run/stop and soft reset control block.
  assumes uhrc_consts.svh is on the include path.
*/
package uhrc_pkg;
  `include "uhrc_consts.svh"

  // ----------------------------------------
  // controller run state, one-hot
  // ----------------------------------------
  typedef enum logic [3:0] {
    UHRC_ST_HALTED  = 4'h1,
    UHRC_ST_RUNNING = 4'h2,
    UHRC_ST_HALTING = 4'h4,
    UHRC_ST_SRST    = 4'h8
  } uhrc_state_t;

  typedef logic [31:0] uhrc_word_t;
endpackage

// ### hdl/uhrc_srst_timer.sv
/*
  soft reset sequencer: holds the reset pulse for a fixed count of cycles.
  assumes start_in is a one-cycle pulse; a new start restarts the count.
*/
`include "uhrc_consts.svh"
module uhrc_srst_timer #(
  parameter int CYCLES = `UHRC_SRST_CYCLES
) (
  // clock and reset
  input wire logic clk_sys_in,
  input wire logic nrst_in,
  // control
  input wire logic start_in,
  output logic busy_out,
  output logic done_out
);
  import uhrc_pkg::*;

  logic [15:0] cnt_ff;
  logic busy_ff;
  logic done_ff;

  // ----------------------------------------
  // count down while busy
  // ----------------------------------------
  always_ff @(posedge clk_sys_in) begin
    if (!nrst_in) begin
      cnt_ff <= 16'h0000;
      busy_ff <= 1'b0;
      done_ff <= 1'b0;
    end else begin
      done_ff <= 1'b0;
      if (start_in) begin
        cnt_ff <= 16'(CYCLES - 1);
        busy_ff <= 1'b1;
      end else if (busy_ff) begin
        if (cnt_ff == 16'h0000) begin
          busy_ff <= 1'b0;
          done_ff <= 1'b1;
        end else begin
          cnt_ff <= cnt_ff - 16'h0001;
        end
      end
    end
  end

  assign busy_out = busy_ff;
  assign done_out = done_ff;
endmodule

// ### hdl/uhrc_port_ctl.sv
/*
  per-port owner and enable state of the root hub.
  assumes writes come from the main block; soft reset returns every port to the companion.
*/
`include "uhrc_consts.svh"
module uhrc_port_ctl #(
  parameter int PORTS = 8
) (
  // clock and reset
  input wire logic clk_sys_in,
  input wire logic nrst_in,
  // soft reset
  input wire logic srst_in,
  // register write
  input wire logic wr_in,
  input wire logic [7:0] wr_sel_in,
  input wire logic [1:0] wr_data_in,
  // state out
  output logic [PORTS-1:0] owner_out,
  output logic [PORTS-1:0] enable_out
);
  import uhrc_pkg::*;

  // ----------------------------------------
  // one owner/enable pair per port
  // ----------------------------------------
  for (genvar p = 0; p < PORTS; p++) begin : g_port
    logic own_ff;
    logic en_ff;
    // soft reset acts just as chip reset here, owner back to companion [RULE_03]
    always_ff @(posedge clk_sys_in) begin
      if (!nrst_in || srst_in) begin
        own_ff <= 1'b1; // [RULE_06]
        en_ff <= 1'b0;
      end else if (wr_in && wr_sel_in == 8'(p)) begin
        own_ff <= wr_data_in[`UHRC_PORT_OWNER_BIT];
        en_ff <= wr_data_in[`UHRC_PORT_ENABLE_BIT];
      end
    end
    assign owner_out[p] = own_ff;
    assign enable_out[p] = en_ff;
  end
endmodule

// ### tb/uhrc_top_chk.sv
/*
  port checker for uhrc_top: run/stop handshake, soft reset, errors.
  assumes one clock domain and the block's register map.
*/
module uhrc_top_chk #(
  parameter int PORTS = 8,
  parameter int SRST_CYCLES = 25
) (
  // clock and reset
  input wire logic clk_sys_in,
  input wire logic nrst_in,
  // register port
  input wire logic [7:0] reg_addr_in,
  input wire uhrc_pkg::uhrc_word_t reg_wdata_in,
  input wire logic reg_wr_in,
  input wire logic reg_rd_in,
  input wire uhrc_pkg::uhrc_word_t reg_rdata_out,
  // schedule engine
  input wire logic xact_busy_in,
  input wire logic mem_rd_done_in,
  input wire logic mem_rd_ok_in,
  input wire logic int_error_in,
  input wire logic sched_run_out,
  input wire logic engine_reset_out,
  // ports and interrupt
  input wire logic [PORTS-1:0] port_owner_out,
  input wire logic [PORTS-1:0] port_enable_out,
  input wire logic [PORTS-1:0] port_bus_reset_out,
  input wire logic irq_out
);
  import uhrc_pkg::*;
  default clocking @(posedge clk_sys_in); endclocking
  default disable iff (!nrst_in);
  // ------
  // helper state
  // ------
  logic cmd_wr;
  logic srst_wr;
  int srst_cnt_ff;
  logic hse_en_ff;
  // command writes, soft reset requests
  assign cmd_wr = reg_wr_in && reg_addr_in == 8'h00;
  assign srst_wr = cmd_wr && reg_wdata_in[1];
  // cycles spent in reset, so the pulse can be bounded
  always_ff @(posedge clk_sys_in) begin
    if (!nrst_in || !engine_reset_out) srst_cnt_ff <= 0;
    else srst_cnt_ff <= srst_cnt_ff + 1;
  end
  // error interrupt enable shadow; survives soft reset
  always_ff @(posedge clk_sys_in) begin
    if (!nrst_in) hse_en_ff <= 1'b0;
    else if (reg_wr_in && reg_addr_in == 8'h08) hse_en_ff <= reg_wdata_in[0];
  end
  // ------
  // sequences and properties
  // ------
  sequence s_start;
    cmd_wr && reg_wdata_in[1:0] == 2'b01 && !engine_reset_out && !int_error_in ##1 !int_error_in;
  endsequence
  sequence s_stop;
    cmd_wr && reg_wdata_in[1:0] == 2'b00 && !engine_reset_out ##1 !xact_busy_in [*3];
  endsequence
  property p_no_bus_reset;
    port_bus_reset_out == '0;
  endproperty
  property p_srst_ports;
    srst_wr && !engine_reset_out |=> engine_reset_out && &port_owner_out && port_enable_out == '0;
  endproperty
  property p_srst_len;
    srst_cnt_ff <= SRST_CYCLES + 3;
  endproperty
  property p_srst_hold;
    cmd_wr && !reg_wdata_in[1] && srst_cnt_ff >= 1 && srst_cnt_ff <= SRST_CYCLES - 3 |=> engine_reset_out;
  endproperty
  property p_srst_read;
    reg_rd_in && reg_addr_in == 8'h00 && srst_cnt_ff >= 1 && srst_cnt_ff <= SRST_CYCLES - 3
      |=> reg_rdata_out[1];
  endproperty
  property p_fls_zero;
    reg_rd_in && reg_addr_in == 8'h00 |=> reg_rdata_out[3:2] == 2'b00;
  endproperty
  property p_start;
    s_start |=> sched_run_out;
  endproperty
  property p_halting_waits;
    sched_run_out && xact_busy_in && !srst_wr && !engine_reset_out && !int_error_in |=> sched_run_out;
  endproperty
  property p_stop_bound;
    s_stop |-> ##[0:1] !sched_run_out;
  endproperty
  property p_hse_irq;
    mem_rd_done_in && !mem_rd_ok_in && hse_en_ff && !engine_reset_out && !srst_wr
      && !(reg_wr_in && reg_addr_in == 8'h08) |=> irq_out;
  endproperty
  a_no_bus_reset: assert property (p_no_bus_reset) else $error("bus reset driven on a port");
  a_srst_ports: assert property (p_srst_ports) else $error("soft reset did not reset ports");
  a_srst_len: assert property (p_srst_len) else $error("soft reset never finished");
  a_srst_hold: assert property (p_srst_hold) else $error("soft reset ended early");
  a_srst_read: assert property (p_srst_read) else $error("soft reset bit read zero");
  a_fls_zero: assert property (p_fls_zero) else $error("frame list size not zero");
  a_start: assert property (p_start) else $error("schedule did not start");
  a_halting_waits: assert property (p_halting_waits) else $error("halted mid transaction");
  a_stop_bound: assert property (p_stop_bound) else $error("schedule did not stop");
  a_hse_irq: assert property (p_hse_irq) else $error("no interrupt on read error");
endmodule

bind uhrc_top uhrc_top_chk #(.PORTS(PORTS), .SRST_CYCLES(SRST_CYCLES)) i_uhrc_top_chk (
  .clk_sys_in, .nrst_in, .reg_addr_in, .reg_wdata_in, .reg_wr_in, .reg_rd_in, .reg_rdata_out, .xact_busy_in,
  .mem_rd_done_in, .mem_rd_ok_in, .int_error_in, .sched_run_out, .engine_reset_out, .port_owner_out,
  .port_enable_out, .port_bus_reset_out, .irq_out);

// ### tb/uhrc_engine_model.sv
/*
  schedule engine model: bus transactions while the schedule runs, read results.
  assumes the bench sets the transaction length and requests faults.
*/
module uhrc_engine_model (
  // clock and reset
  input wire logic clk_sys_in,
  input wire logic nrst_in,
  // from the control block
  input wire logic sched_run_in,
  input wire logic engine_reset_in,
  // bench requests
  input wire logic [7:0] xact_len_in,
  input wire logic fail_in,
  input wire logic err_in,
  // to the control block
  output logic xact_busy_out,
  output logic mem_rd_done_out,
  output logic mem_rd_ok_out,
  output logic int_error_out
);
  logic [7:0] left_ff;
  // four idle cycles between transactions let a halt land
  always_ff @(posedge clk_sys_in) begin
    if (!nrst_in || engine_reset_in) begin
      xact_busy_out <= 1'b0;
      left_ff <= 8'h00;
    end else if (left_ff != 8'h00) begin
      left_ff <= xact_busy_out && left_ff == 8'h01 ? 8'h03 : left_ff - 8'h01;
      if (left_ff == 8'h01) xact_busy_out <= 1'b0;
    end else if (sched_run_in) begin
      xact_busy_out <= 1'b1;
      left_ff <= xact_len_in;
    end
  end
  // good read at each transaction end; ok line toggles when not qualified
  always_ff @(posedge clk_sys_in) begin
    mem_rd_done_out <= fail_in || (xact_busy_out && left_ff == 8'h01);
    mem_rd_ok_out <= !nrst_in ? 1'b0 : fail_in ? 1'b0 : mem_rd_done_out ? ~mem_rd_ok_out : 1'b1;
    int_error_out <= err_in;
  end
endmodule

// ### tb/usb2_host_run_reset_control_bench.sv
/*
  self-checking bench for uhrc_top with the engine model on its far side.
  assumes the checker binds itself; reads are scored a cycle later.
*/
module usb2_host_run_reset_control_bench;
  timeunit 1ns;
  timeprecision 1ps;
  import uhrc_pkg::*;
  localparam int NP = 8;
  localparam int SRST = 8;
  localparam uhrc_word_t CAP = 32'h0000C3C3; // arbitrary value
  typedef struct packed {uhrc_word_t e; uhrc_word_t m;} uhrc_note_t;
  logic clk_sys_in = 1'b0;
  logic nrst_in = 1'b0;
  logic [7:0] reg_addr_in = 8'h00;
  uhrc_word_t reg_wdata_in = 32'h0;
  logic reg_wr_in = 1'b0;
  logic reg_rd_in = 1'b0;
  uhrc_word_t reg_rdata_out;
  logic xact_busy, rd_done, rd_ok, int_err, sched_run_out, engine_reset_out, irq_out;
  logic [NP-1:0] port_owner_out, port_enable_out, port_bus_reset_out, own_e, en_e;
  logic [7:0] xact_len = 8'h1E;
  logic fail_req = 1'b0;
  logic err_req = 1'b0;
  logic rd_d = 1'b0;
  logic [31:0] rng = 32'h802F;
  uhrc_note_t note_q[$];
  uhrc_note_t note;
  int n_mismatch = 0;
  int checks = 0;
  always #20 clk_sys_in = ~clk_sys_in;
  uhrc_top #(.PORTS(NP), .SRST_CYCLES(SRST), .CAP_ID(CAP)) i_uhrc_top (.clk_sys_in, .nrst_in, .reg_addr_in,
    .reg_wdata_in, .reg_wr_in, .reg_rd_in, .reg_rdata_out, .xact_busy_in(xact_busy), .mem_rd_done_in(rd_done),
    .mem_rd_ok_in(rd_ok), .int_error_in(int_err), .sched_run_out, .engine_reset_out, .port_owner_out,
    .port_enable_out, .port_bus_reset_out, .irq_out);
  uhrc_engine_model i_uhrc_engine_model (.clk_sys_in, .nrst_in,
    .sched_run_in(sched_run_out), .engine_reset_in(engine_reset_out), .xact_len_in(xact_len),
    .fail_in(fail_req), .err_in(err_req), .xact_busy_out(xact_busy), .mem_rd_done_out(rd_done),
    .mem_rd_ok_out(rd_ok), .int_error_out(int_err));
  // ------
  // helpers
  // ------
  function automatic logic [31:0] xs(input logic [31:0] s);
    s = s ^ (s << 13);
    s = s ^ (s >> 17);
    return s ^ (s << 5);
  endfunction
  task automatic check(input uhrc_word_t seen, input uhrc_word_t exp, input string what);
    checks++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("unexpected %s: expected %h seen %h", what, exp, seen);
    end
  endtask
  // one strobe cycle; the strobe drops on the edge that takes it
  task automatic bus(input logic w, input logic [7:0] a, input uhrc_word_t d);
    @(posedge clk_sys_in);
    reg_addr_in <= a;
    reg_wdata_in <= d;
    reg_wr_in <= w;
    reg_rd_in <= !w;
    @(posedge clk_sys_in);
    reg_wr_in <= 1'b0;
    reg_rd_in <= 1'b0;
  endtask
  task automatic wr(input logic [7:0] a, input uhrc_word_t d);
    bus(1'b1, a, d);
  endtask
  task automatic rd(input logic [7:0] a, input uhrc_word_t e, input uhrc_word_t m);
    note_q.push_back('{e, m});
    bus(1'b0, a, 32'h0);
  endtask
  // fault request, then time for status and interrupt to land
  task automatic pulse(input logic f);
    @(posedge clk_sys_in);
    fail_req <= f;
    err_req <= !f;
    @(posedge clk_sys_in);
    fail_req <= 1'b0;
    err_req <= 1'b0;
    repeat (3) @(posedge clk_sys_in);
    #1;
  endtask
  // bounded wait for run or engine reset to reach a level
  task automatic wait_lvl(input logic sel, input logic want, input string what);
    int i;
    #1;
    for (i = 0; i < 300 && (sel ? engine_reset_out : sched_run_out) !== want; i++) begin
      @(posedge clk_sys_in);
      #1;
    end
    check(sel ? engine_reset_out : sched_run_out, want, what);
  endtask
  task automatic summarize;
    $display("checks %0d mismatches %0d", checks, n_mismatch);
    if (n_mismatch == 0 && checks > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  // read data stand one cycle after the strobe: score them against the oldest note
  always @(posedge clk_sys_in) begin
    if (rd_d) begin
      note = note_q.pop_front();
      check(reg_rdata_out & note.m, note.e & note.m, "read data");
    end
    rd_d <= reg_rd_in;
  end
  // watchdog, far beyond the test length
  initial begin
    #(40 * 5000);
    n_mismatch++;
    $display("watchdog expired");
    summarize();
  end
  // ------
  // tests
  // ------
  initial begin
    repeat (16) @(posedge clk_sys_in);
    nrst_in <= 1'b1;
    rd(8'h04, 32'h00001000, 32'h00001010);
    rd(8'h00, 32'h0, 32'hF);
    rng = xs(rng);
    wr(8'hFC, rng);
    rd(8'hFC, CAP, '1);
    rd(8'h40, 32'h0, '1);
    rng = xs(rng);
    wr(8'h00, (rng & 32'hFFFFFFFC) | 32'hC);
    rd(8'h00, 32'h0, 32'hF);
    $display("test map done");
    own_e = '1;
    en_e = '0;
    for (int k = 0; k < 6; k++) begin
      rng = xs(rng);
      wr(8'h10 + {3'b000, rng[2:0], 2'b00}, {30'h0, rng[9:8]});
      own_e[rng[2:0]] = rng[8];
      en_e[rng[2:0]] = rng[9];
      rd(8'h10 + {3'b000, rng[2:0], 2'b00}, {30'h0, rng[9:8]}, 32'h3);
    end
    check(port_owner_out, own_e, "port owner");
    check(port_enable_out, en_e, "port enable");
    $display("test ports done");
    wr(8'h08, 32'h7);
    wr(8'h00, 32'h1);
    rd(8'h04, 32'h0, 32'h1000);
    rd(8'h00, 32'h1, 32'h1);
    wait_lvl(1'b0, 1'b1, "run");
    wr(8'h00, 32'h0);
    rd(8'h04, 32'h0, 32'h1000);
    check(sched_run_out, 1'b1, "run while halting");
    wait_lvl(1'b0, 1'b0, "run");
    rd(8'h04, 32'h1000, 32'h1000);
    rd(8'h0C, 32'h2, 32'h2);
    check(irq_out, 1'b1, "irq");
    wr(8'h0C, 32'h2);
    #1;
    check(irq_out, 1'b0, "irq");
    $display("test run halt done");
    xact_len <= 8'h01;
    wr(8'h00, 32'h1);
    wait_lvl(1'b0, 1'b1, "run");
    pulse(1'b0);
    wait_lvl(1'b0, 1'b0, "run");
    rd(8'h04, 32'h1000, 32'h1000);
    rd(8'h00, 32'h0, 32'h1);
    wr(8'h0C, 32'h7);
    $display("test error halt done");
    wr(8'h08, 32'h0);
    pulse(1'b1);
    check(irq_out, 1'b0, "masked irq");
    rd(8'h04, 32'h1010, 32'h1010);
    wr(8'h04, 32'h10);
    wr(8'h0C, 32'h1);
    wr(8'h08, 32'h7);
    pulse(1'b1);
    check(irq_out, 1'b1, "irq");
    rd(8'h0C, 32'h1, 32'h1);
    $display("test host error done");
    wr(8'h14, 32'h2);
    wr(8'h00, 32'h2);
    rd(8'h00, 32'h2, 32'h2);
    wr(8'h00, 32'h0);
    rd(8'h00, 32'h2, 32'h2);
    wait_lvl(1'b1, 1'b0, "engine reset");
    rd(8'h00, 32'h0, 32'hF);
    rd(8'h04, 32'h1000, 32'h1010);
    rd(8'h0C, 32'h4, 32'h4);
    rd(8'h08, 32'h7, 32'h7);
    rd(8'hFC, CAP, '1);
    check(port_owner_out, 32'hFF, "port owner");
    check(port_enable_out, 32'h0, "port enable");
    check(port_bus_reset_out, 32'h0, "port bus reset");
    wr(8'h0C, 32'h7);
    wr(8'h00, 32'h1);
    wait_lvl(1'b0, 1'b1, "run");
    wr(8'h00, 32'h0);
    wait_lvl(1'b0, 1'b0, "run");
    $display("test soft reset done");
    repeat (3) @(posedge clk_sys_in);
    summarize();
  end
endmodule
